// [hw/irq_enable_pkg.sv]
// constants for the interrupt enable bank: bus map, bit positions,
// the word 0 implemented-bit mask and reset values; shared by design and bench
package irq_enable_pkg;
  // geometry
  localparam int WORDS = 4;
  localparam int WORD_W = 16;
  localparam int SRC_N = WORDS * WORD_W;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  // byte offsets of the three register groups, word 0..3 each
  localparam logic [5:0] EN_BASE = 6'h00;
  localparam logic [5:0] FLAG_BASE = 6'h10;
  localparam logic [5:0] CLR_BASE = 6'h20;
  // address fields
  localparam int GRP_HI = 5;
  localparam int GRP_LO = 4;
  localparam int IDX_HI = 3;
  localparam int IDX_LO = 2;
  // reset value of enable and flag words
  localparam logic [15:0] WORD_RST = 16'h0000;
  // word 0 bit positions
  localparam int OCMP_CH1_BIT = 2;
  localparam int ICAP_CH1_BIT = 1;
  localparam int EXT_IN0_BIT = 0;
  localparam logic [15:0] W0_OTHER = 16'h3fe8;
  // word 1 bit positions
  localparam int SER2_TX_BIT = 15;
  localparam int SER2_RX_BIT = 14;
  localparam int EXT_IN2_BIT = 13;
  localparam int TIMER5_BIT = 12;
  localparam int TIMER4_BIT = 11;
  localparam int OCMP_CH4_BIT = 10;
  localparam int OCMP_CH3_BIT = 9;
  localparam int EXT_IN1_BIT = 4;
  localparam int PIN_CHG_BIT = 3;
  localparam int COMPAR_BIT = 2;
  localparam int TW1_MASTER_BIT = 1;
  localparam int TW1_SLAVE_BIT = 0;
  // word 2 bit positions
  localparam int PAR_PORT_BIT = 13;
  localparam int OCMP_CH5_BIT = 9;
  localparam int ICAP_CH5_BIT = 7;
  localparam int ICAP_CH4_BIT = 6;
  localparam int ICAP_CH3_BIT = 5;
  localparam int SP2_EVENT_BIT = 1;
  localparam int SP2_FAULT_BIT = 0;
  // word 3 bit positions
  localparam int CALENDAR_BIT = 14;
  localparam int TW2_MASTER_BIT = 2;
  localparam int TW2_SLAVE_BIT = 1;
endpackage

// [hw/interrupt_enable_mask_bank.sv]
// interrupt enable bank: four 16-bit enable words, sticky request
// flags with write-one-to-clear, masked per-source requests, one irq.
// assumes an avalon-mm master on MCLK and source requests synchronous
// to MCLK; priority fields live outside and arrive as a nonzero flag.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - enable one passes request, zero masks it
// - unimplemented enable bits ignore writes, read zero
// - reset clears every enable bit to zero
// - word0 bit2 compare1, bit1 capture1
// - external inputs: w0 b0, w1 b4, w1 b13
// - word1 bits 15,14 serial2 transmit, receive
// - word1 bits 12,11 timer five, four
// - word1 bits 10,9 compare4,3; 8-5 absent
// - word1 bit3 pin change, bit2 comparator
// - word1 bits 1,0 twowire1 master, slave
// - word2 bit13 parallel port, bit9 compare5
// - word2 bits 7,6,5 capture 5,4,3
// - word2 bits 1,0 serial periph2 event, fault
// - word3 bit14 calendar, others mostly absent
// - word3 bits 2,1 twowire2 master, slave
// - flag sets on request regardless of enable
// - zero priority field disables the source
module interrupt_enable_mask_bank (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [irq_enable_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [irq_enable_pkg::DATA_W-1:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [irq_enable_pkg::DATA_W-1:0] READDATA,
  output logic WAITREQUEST,
  input wire logic [irq_enable_pkg::SRC_N-1:0] SRC_REQ,
  input wire logic [irq_enable_pkg::SRC_N-1:0] SRC_PRIO_LIVE,
  output logic [irq_enable_pkg::SRC_N-1:0] MASKED_REQ,
  output logic IRQ
);
  import irq_enable_pkg::*;

  // word slots and byte lane width inside the bank
  localparam int WORD0 = 0;
  localparam int WORD1 = 1;
  localparam int WORD2 = 2;
  localparam int WORD3 = 3;
  localparam int LANE_W = 8;

  // flat source position of a bit inside a word
  function automatic int src_pos(input int word, input int pos);
    return word * WORD_W + pos;
  endfunction

  // implemented positions of each enable and flag word
  function automatic logic [15:0] impl_mask(input logic [1:0] idx);
    logic [15:0] m;
    m = WORD_RST;
    unique case (idx)
      2'h0: begin
        m[OCMP_CH1_BIT] = 1'b1;
        m[ICAP_CH1_BIT] = 1'b1;
        m[EXT_IN0_BIT] = 1'b1;
        m = m | W0_OTHER;
      end
      2'h1: begin
        m[SER2_TX_BIT] = 1'b1;
        m[SER2_RX_BIT] = 1'b1;
        m[EXT_IN2_BIT] = 1'b1;
        m[EXT_IN1_BIT] = 1'b1;
        m[TIMER5_BIT] = 1'b1;
        m[TIMER4_BIT] = 1'b1;
        m[OCMP_CH4_BIT] = 1'b1;
        m[OCMP_CH3_BIT] = 1'b1;
        m[PIN_CHG_BIT] = 1'b1;
        m[COMPAR_BIT] = 1'b1;
        m[TW1_MASTER_BIT] = 1'b1;
        m[TW1_SLAVE_BIT] = 1'b1;
      end
      2'h2: begin
        m[PAR_PORT_BIT] = 1'b1;
        m[OCMP_CH5_BIT] = 1'b1;
        m[ICAP_CH5_BIT] = 1'b1;
        m[ICAP_CH4_BIT] = 1'b1;
        m[ICAP_CH3_BIT] = 1'b1;
        m[SP2_EVENT_BIT] = 1'b1;
        m[SP2_FAULT_BIT] = 1'b1;
      end
      2'h3: begin
        m[CALENDAR_BIT] = 1'b1;
        m[TW2_MASTER_BIT] = 1'b1;
        m[TW2_SLAVE_BIT] = 1'b1;
      end
    endcase
    return m;
  endfunction

  // merge write data into a word under the two low byte lanes
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old,
    input logic [15:0] wdat,
    input logic [1:0] be
  );
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[LANE_W-1:0] = wdat[LANE_W-1:0];
    end
    if (be[1]) begin
      r[WORD_W-1:LANE_W] = wdat[WORD_W-1:LANE_W];
    end
    return r;
  endfunction

  // storage
  logic [15:0] en_reg [WORDS];
  logic [15:0] flag_reg [WORDS];
  logic [SRC_N-1:0] masked_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic ack_reg;

  // decode of the current request
  logic req;
  logic [1:0] grp;
  logic [1:0] idx;
  logic hit_en;
  logic hit_flag;
  logic hit_clr;
  logic wr_take;
  logic [15:0] wr_word;

  assign req = READ | WRITE;
  assign grp = ADDRESS[GRP_HI:GRP_LO];
  assign idx = ADDRESS[IDX_HI:IDX_LO];
  assign hit_en = (grp == EN_BASE[GRP_HI:GRP_LO]);
  assign hit_flag = (grp == FLAG_BASE[GRP_HI:GRP_LO]);
  assign hit_clr = (grp == CLR_BASE[GRP_HI:GRP_LO]);
  assign wr_word = WRITEDATA[WORD_W-1:0];

  // named enable view plus the word 0 W0_OTHER bits; forwarding reads only those, so a stray bit in
  // an absent position can never raise a request toward the core
  // word 0 sources
  logic ocmp_ch1_en;
  logic icap_ch1_en;
  logic ext_irq_in0_en;
  // word 1 sources
  logic serial2_tx_en;
  logic serial2_rx_en;
  logic ext_irq_in2_en;
  logic timer_five_en;
  logic timer_four_en;
  logic ocmp_ch4_en;
  logic ocmp_ch3_en;
  logic ext_irq_in1_en;
  logic pin_change_en;
  logic comparator_en;
  logic twowire1_master_en;
  logic twowire1_slave_en;
  // word 2 sources
  logic par_port_en;
  logic ocmp_ch5_en;
  logic icap_ch5_en;
  logic icap_ch4_en;
  logic icap_ch3_en;
  logic serial_periph2_event_en;
  logic serial_periph2_fault_en;
  // word 3 sources
  logic calendar_en;
  logic twowire2_master_en;
  logic twowire2_slave_en;
  // flat enable vector handed to the forwarding stage
  logic [SRC_N-1:0] en_vec;

  // word 0 taps
  // compare1, capture1
  assign ocmp_ch1_en = en_reg[WORD0][OCMP_CH1_BIT];
  assign icap_ch1_en = en_reg[WORD0][ICAP_CH1_BIT];
  assign ext_irq_in0_en = en_reg[WORD0][EXT_IN0_BIT];

  // word 1 taps
  // second serial port
  assign serial2_tx_en = en_reg[WORD1][SER2_TX_BIT];
  assign serial2_rx_en = en_reg[WORD1][SER2_RX_BIT];
  assign ext_irq_in2_en = en_reg[WORD1][EXT_IN2_BIT];
  assign ext_irq_in1_en = en_reg[WORD1][EXT_IN1_BIT];
  assign timer_five_en = en_reg[WORD1][TIMER5_BIT];
  assign timer_four_en = en_reg[WORD1][TIMER4_BIT];
  assign ocmp_ch4_en = en_reg[WORD1][OCMP_CH4_BIT];
  assign ocmp_ch3_en = en_reg[WORD1][OCMP_CH3_BIT];
  assign pin_change_en = en_reg[WORD1][PIN_CHG_BIT];
  assign comparator_en = en_reg[WORD1][COMPAR_BIT];
  assign twowire1_master_en = en_reg[WORD1][TW1_MASTER_BIT];
  assign twowire1_slave_en = en_reg[WORD1][TW1_SLAVE_BIT];

  // word 2 taps
  // parallel port, compare5
  assign par_port_en = en_reg[WORD2][PAR_PORT_BIT];
  assign ocmp_ch5_en = en_reg[WORD2][OCMP_CH5_BIT];
  assign icap_ch5_en = en_reg[WORD2][ICAP_CH5_BIT];
  assign icap_ch4_en = en_reg[WORD2][ICAP_CH4_BIT];
  assign icap_ch3_en = en_reg[WORD2][ICAP_CH3_BIT];
  assign serial_periph2_event_en = en_reg[WORD2][SP2_EVENT_BIT];
  assign serial_periph2_fault_en = en_reg[WORD2][SP2_FAULT_BIT];

  // word 3 taps
  // calendar
  assign calendar_en = en_reg[WORD3][CALENDAR_BIT];
  assign twowire2_master_en = en_reg[WORD3][TW2_MASTER_BIT];
  assign twowire2_slave_en = en_reg[WORD3][TW2_SLAVE_BIT];

  // flat vector from the named taps; word 0 keeps its other sources whole
  always_comb begin
    en_vec = '0;
    en_vec[WORD0*WORD_W +: WORD_W] = en_reg[WORD0] & W0_OTHER;
    en_vec[src_pos(WORD0, OCMP_CH1_BIT)] = ocmp_ch1_en;
    en_vec[src_pos(WORD0, ICAP_CH1_BIT)] = icap_ch1_en;
    en_vec[src_pos(WORD0, EXT_IN0_BIT)] = ext_irq_in0_en;
    // word 1
    en_vec[src_pos(WORD1, SER2_TX_BIT)] = serial2_tx_en;
    en_vec[src_pos(WORD1, SER2_RX_BIT)] = serial2_rx_en;
    en_vec[src_pos(WORD1, EXT_IN2_BIT)] = ext_irq_in2_en;
    en_vec[src_pos(WORD1, TIMER5_BIT)] = timer_five_en;
    en_vec[src_pos(WORD1, TIMER4_BIT)] = timer_four_en;
    en_vec[src_pos(WORD1, OCMP_CH4_BIT)] = ocmp_ch4_en;
    en_vec[src_pos(WORD1, OCMP_CH3_BIT)] = ocmp_ch3_en;
    en_vec[src_pos(WORD1, EXT_IN1_BIT)] = ext_irq_in1_en;
    en_vec[src_pos(WORD1, PIN_CHG_BIT)] = pin_change_en;
    en_vec[src_pos(WORD1, COMPAR_BIT)] = comparator_en;
    en_vec[src_pos(WORD1, TW1_MASTER_BIT)] = twowire1_master_en;
    en_vec[src_pos(WORD1, TW1_SLAVE_BIT)] = twowire1_slave_en;
    // word 2
    en_vec[src_pos(WORD2, PAR_PORT_BIT)] = par_port_en;
    en_vec[src_pos(WORD2, OCMP_CH5_BIT)] = ocmp_ch5_en;
    en_vec[src_pos(WORD2, ICAP_CH5_BIT)] = icap_ch5_en;
    en_vec[src_pos(WORD2, ICAP_CH4_BIT)] = icap_ch4_en;
    en_vec[src_pos(WORD2, ICAP_CH3_BIT)] = icap_ch3_en;
    en_vec[src_pos(WORD2, SP2_EVENT_BIT)] = serial_periph2_event_en;
    en_vec[src_pos(WORD2, SP2_FAULT_BIT)] = serial_periph2_fault_en;
    // word 3
    en_vec[src_pos(WORD3, CALENDAR_BIT)] = calendar_en;
    en_vec[src_pos(WORD3, TW2_MASTER_BIT)] = twowire2_master_en;
    en_vec[src_pos(WORD3, TW2_SLAVE_BIT)] = twowire2_slave_en;
  end

  // flat flag vector, same layout as the enable view
  logic [SRC_N-1:0] flag_vec;
  always_comb begin
    flag_vec = '0;
    for (int i = 0; i < WORDS; i++) begin
      flag_vec[i*WORD_W +: WORD_W] = flag_reg[i];
    end
  end

  // one wait cycle per access; the write lands on the released edge
  assign WAITREQUEST = req & ~ack_reg;
  // the first cycle only decodes, so a write never lands while waiting
  assign wr_take = WRITE & ack_reg;

  // ack toggles so back-to-back requests each get one wait cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // enable words, software written
  // lanes two and three carry no bits here and are ignored
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < WORDS; i++) begin
        en_reg[i] <= WORD_RST;
      end
    end else if (wr_take && hit_en) begin
      en_reg[idx] <= lane_merge(en_reg[idx], wr_word, BYTEENABLE[1:0])
        & impl_mask(idx);
    end
  end

  // sticky flags; a request in the clearing cycle survives the clear
  // absent positions are cut at the input, so they never set
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < WORDS; i++) begin
        flag_reg[i] <= WORD_RST;
      end
    end else begin
      for (int i = 0; i < WORDS; i++) begin
        logic [15:0] clr;
        logic [15:0] set;
        clr = WORD_RST;
        if (wr_take && hit_clr && idx == 2'(i)) begin
          clr = lane_merge(WORD_RST, wr_word, BYTEENABLE[1:0]);
        end
        set = SRC_REQ[i*WORD_W +: WORD_W] & impl_mask(2'(i));
        flag_reg[i] <= (flag_reg[i] & ~clr) | set;
      end
    end
  end

  // read data is built while waitrequest is high, stands when it drops
  // clear group and unmapped group fall through and read as zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= '0;
    end else if (READ && !ack_reg) begin
      rdata_reg <= '0;
      if (hit_en) begin
        rdata_reg[WORD_W-1:0] <= en_reg[idx] & impl_mask(idx);
      end else if (hit_flag) begin
        rdata_reg[WORD_W-1:0] <= flag_reg[idx];
      end
    end
  end

  assign READDATA = rdata_reg;

  // masked requests toward the core, refreshed every clock
  // one cycle behind the flags, so the core sees a registered vector
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      masked_reg <= '0;
    end else begin
      for (int i = 0; i < WORDS; i++) begin
        masked_reg[i*WORD_W +: WORD_W] <= flag_vec[i*WORD_W +: WORD_W]
          & en_vec[i*WORD_W +: WORD_W]
          & SRC_PRIO_LIVE[i*WORD_W +: WORD_W];
      end
    end
  end

  assign MASKED_REQ = masked_reg;

  // single level interrupt, only flops feed it so it has no glitches
  // stays high until software clears the flag or drops the enable, or the source's priority field goes to zero
  assign IRQ = |masked_reg;

endmodule

`default_nettype wire

// [sim/irq_bank_properties.sv]
// port checker for the enable bank
// bound to each instance, sees top ports only
`timescale 1ns/1ps
`default_nettype none
module irq_bank_properties (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  input wire logic [63:0] SRC_PRIO_LIVE,
  input wire logic [63:0] MASKED_REQ,
  input wire logic IRQ
);
  localparam logic [63:0] IMPL = 64'h4006_22e3_fe1f_3fef;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // bus answers after one wait state
  a_read_wait: assert property ($rose(READ) |-> WAITREQUEST ##1 !WAITREQUEST)
    else $error("read wait state wrong");
  a_write_wait: assert property ($rose(WRITE) |-> WAITREQUEST ##1 !WAITREQUEST)
    else $error("write wait state wrong");
  a_upper_zero: assert property (READ && !WAITREQUEST |-> READDATA[31:16] == 16'h0)
    else $error("upper read half not zero");
  // masked outputs never leave implemented or live sources
  a_absent_quiet: assert property ((MASKED_REQ & ~IMPL) == 64'h0)
    else $error("absent source forwarded");
  a_prio_gate: assert property ((MASKED_REQ & ~$past(SRC_PRIO_LIVE)) == 64'h0)
    else $error("zero priority source forwarded");
  a_irq_any: assert property (IRQ == (|MASKED_REQ))
    else $error("irq differs from masked requests");
  // a sticky flag only drops after a bus write
  a_flag_sticky: assert property (|($past(MASKED_REQ) & ~MASKED_REQ & $past(SRC_PRIO_LIVE))
    |-> $past(WRITE) || $past(WRITE, 2))
    else $error("masked request dropped alone");
  a_reset_quiet: assert property (disable iff (1'b0) RST |-> !IRQ && MASKED_REQ == 64'h0)
    else $error("outputs live in reset");
  c_irq: cover property ($rose(IRQ));
  c_read: cover property (READ && !WAITREQUEST);
  c_clear: cover property ($fell(IRQ));
endmodule
bind interrupt_enable_mask_bank irq_bank_properties irq_bank_properties_inst (
  .MCLK(MCLK), .RST(RST), .READ(READ), .WRITE(WRITE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .SRC_PRIO_LIVE(SRC_PRIO_LIVE),
  .MASKED_REQ(MASKED_REQ), .IRQ(IRQ));
`default_nettype wire

// [sim/src_model.sv]
// request source model: one-cycle request per fire strobe
// assumes fire and idx change just after MCLK rises
`timescale 1ns/1ps
`default_nettype none
module src_model (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic fire,
  input wire logic [5:0] idx,
  input wire logic [63:0] live,
  output logic [63:0] SRC_REQ,
  output logic [63:0] SRC_PRIO_LIVE
);
  // priority fields nonzero where live is set
  assign SRC_PRIO_LIVE = live;
  // request pulse; lines idle low between pulses
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) SRC_REQ <= 64'h0;
    else SRC_REQ <= fire ? (64'h1 << idx) : 64'h0;
  end
endmodule
`default_nettype wire

// [sim/tb_interrupt_enable_mask_bank.sv]
// self-checking bench for the enable bank
// drives the avalon slave and the source model from mclk
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_enable_mask_bank;
  import irq_enable_pkg::*;
  logic mclk = 0, rst = 1, rd = 0, wr = 0, fire = 0, wait_rq, irq;
  logic [5:0] addr = '0, idx = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [3:0] be = 4'hf;
  logic [63:0] live = '1, src, prio, mreq;
  logic [15:0] impl [4] = '{16'h3fef, 16'hfe1f, 16'h22e3, 16'h4006};
  int n_fail = 0, checks_done = 0, cyc = 0;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t: value mismatch", $time); end end
  always #2.5 mclk = ~mclk;
  src_model src_model_inst (.MCLK(mclk), .RST(rst), .fire(fire), .idx(idx), .live(live),
    .SRC_REQ(src), .SRC_PRIO_LIVE(prio));
  interrupt_enable_mask_bank interrupt_enable_mask_bank_inst (.MCLK(mclk), .RST(rst),
    .ADDRESS(addr), .READ(rd), .WRITE(wr), .WRITEDATA(wdat), .BYTEENABLE(be),
    .READDATA(rdat), .WAITREQUEST(wait_rq), .SRC_REQ(src), .SRC_PRIO_LIVE(prio),
    .MASKED_REQ(mreq), .IRQ(irq));
  task stop_test();
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= {16'h0, d};
    do @(posedge mclk); while (wait_rq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // request then wait out flag and masked stages
  task automatic pulse(input logic [5:0] k);
    fire <= 1'b1;
    idx <= k;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // hang guard, well above the ~700 cycles the tests take
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int w = 0; w < 4; w++) begin
      bus(0, 6'(4 * w), 0);
      `CHK(q, 32'h0)
      bus(1, 6'(4 * w), 16'hffff);
      bus(0, 6'(4 * w), 0);
      `CHK(q, {16'h0, impl[w]})
    end
    // status is read-only, clear and unmapped read zero
    bus(1, FLAG_BASE, 16'hffff);
    bus(0, FLAG_BASE, 0);
    `CHK(q, 32'h0)
    bus(0, CLR_BASE, 0);
    `CHK(q, 32'h0)
    bus(1, 6'h30, 16'hffff);
    bus(0, 6'h30, 0);
    `CHK(q, 32'h0)
    // every source position, then cleared again
    for (int k = 0; k < 64; k++) begin
      pulse(6'(k));
      `CHK(mreq[k], impl[k / 16][k % 16])
      `CHK(irq, impl[k / 16][k % 16])
      bus(1, CLR_BASE | 6'(4 * (k / 16)), 16'h1 << (k % 16));
      repeat (2) @(posedge mclk);
      `CHK(irq, 1'b0)
    end
    // masked source still flags; zero priority holds it off
    bus(1, 6'h00, 16'h0);
    pulse(6'd1);
    `CHK(mreq[1], 1'b0)
    bus(0, FLAG_BASE, 0);
    `CHK(q, 32'h2)
    live <= ~64'h2;
    bus(1, 6'h00, 16'h0002);
    repeat (2) @(posedge mclk);
    `CHK(mreq[1], 1'b0)
    live <= '1;
    repeat (2) @(posedge mclk);
    `CHK(mreq[1], 1'b1)
    // low lane only, then a second reset
    be <= 4'h1;
    bus(1, 6'h04, 16'h0);
    be <= 4'hf;
    bus(0, 6'h04, 0);
    `CHK(q, 32'hfe00)
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    bus(0, 6'h04, 0);
    `CHK(q, 32'h0)
    stop_test();
  end
endmodule
`default_nettype wire
